//--- rtl/dmap_pkg.sv
/*
 * constants, types and decode functions of the serial memory access port.
 * assumes one system clock domain; the bus pins are synchronised inside the port.
 */
`default_nettype none
package dmap_pkg;
    // bus address, upper six bits; the last bit comes from the pin
    localparam logic [5:0]  DMAP_DEV_ADDR_HI = 6'h0f;
    // memory map
    localparam logic [15:0] DMAP_PROGRAM_RAM_BASE   = 16'h2000;
    localparam logic [15:0] DMAP_PROGRAM_RAM_LAST   = 16'h25ff;
    localparam logic [15:0] DMAP_PROGRAM_ROM_BASE   = 16'h8000;
    localparam logic [15:0] DMAP_PROGRAM_ROM_LAST   = 16'h87ff;
    localparam logic [15:0] DMAP_DATA_LAST   = 16'h09ff;
    localparam logic [15:0] DMAP_COEF_BASE   = 16'h1000;
    localparam logic [15:0] DMAP_COEF_LAST   = 16'h11ff;
    localparam logic [15:0] DMAP_STAT_LO     = 16'h0ff2;
    localparam logic [15:0] DMAP_STAT_HI     = 16'h0ff3;
    localparam logic [15:0] DMAP_CTRL        = 16'h602f;
    localparam int          DMAP_PROGRAM_RAM_DEPTH  = 1536;
    // bytes per word
    localparam logic [2:0]  DMAP_LEN_PROG    = 3'h4;
    localparam logic [2:0]  DMAP_LEN_DATA    = 3'h3;
    localparam logic [2:0]  DMAP_LEN_COEF    = 3'h2;
    // control register reset value and writable bits
    localparam logic [23:0] DMAP_CTRL_RESET  = 24'h0050c6;
    localparam logic [23:0] DMAP_CTRL_WMASK  = 24'h3cf97e;
    // control field positions
    localparam int          DMAP_DIV_LSB     = 1;
    localparam int          DMAP_DOUBLE_BIT  = 6;
    localparam int          DMAP_HOLD_BIT    = 8;
    localparam int          DMAP_MULT_LSB    = 11;
    localparam int          DMAP_RANGE_LSB   = 14;
    localparam int          DMAP_CONV_LSB    = 18;
    localparam int          DMAP_PINOFF_BIT  = 20;
    localparam int          DMAP_FIXED_BIT   = 21;
    // channel status registers
    localparam logic [19:0] DMAP_STAT_RESET  = 20'h00000;

    // target addressed by a memory address
    typedef enum logic [2:0] {
        TGT_PROGRAM_RAM, TGT_PROGRAM_ROM, TGT_DATA, TGT_COEF, TGT_CTRL, TGT_STLO, TGT_STHI, TGT_RSVD
    } dmap_target_t;

    // protocol states
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_ADRH, ST_ADRL, ST_WR, ST_RD, ST_SKIP
    } dmap_state_t;

    // address decode, used for both reading and writing
    function automatic dmap_target_t dmap_decode(input logic [15:0] a);
        if (a >= DMAP_PROGRAM_RAM_BASE && a <= DMAP_PROGRAM_RAM_LAST) return TGT_PROGRAM_RAM;
        if (a >= DMAP_PROGRAM_ROM_BASE && a <= DMAP_PROGRAM_ROM_LAST) return TGT_PROGRAM_ROM;
        if (a <= DMAP_DATA_LAST) return TGT_DATA;
        if (a >= DMAP_COEF_BASE && a <= DMAP_COEF_LAST) return TGT_COEF;
        if (a == DMAP_CTRL) return TGT_CTRL;
        if (a == DMAP_STAT_LO) return TGT_STLO;
        if (a == DMAP_STAT_HI) return TGT_STHI;
        return TGT_RSVD;
    endfunction

    // bytes per word of a target
    function automatic logic [2:0] dmap_word_len(input dmap_target_t t);
        case (t)
            TGT_PROGRAM_RAM, TGT_PROGRAM_ROM: return DMAP_LEN_PROG;
            TGT_COEF:           return DMAP_LEN_COEF;
            default:            return DMAP_LEN_DATA;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- rtl/dmap_sync.sv
/*
 * two flip-flop synchroniser for a group of pin levels.
 * assumes the pins idle high, so both stages reset to one.
 */
`timescale 1ns/1ns
`default_nettype none
module dmap_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    // levels in and out
    input  wire logic [WIDTH-1:0] asyncIn,
    output var  logic [WIDTH-1:0] syncOut
);
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gSync
            logic stage1;   // first stage, read only by the second
            // two stages per pin level
            always_ff @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    stage1     <= 1'b1;
                    syncOut[g] <= 1'b1;
                end else begin
                    stage1     <= asyncIn[g];
                    syncOut[g] <= stage1;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

//--- rtl/dmap_mem.sv
/*
 * single port write, registered read memory for the program RAM.
 * assumes write and read addresses are inside the depth.
 */
`timescale 1ns/1ns
`default_nettype none
module dmap_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 1536,
    parameter int AW    = 11
) (
    // clock
    input  wire logic             clk_sys,
    // write side
    input  wire logic             writeEn,
    input  wire logic [AW-1:0]    writeAddr,
    input  wire logic [WIDTH-1:0] writeData,
    // read side
    input  wire logic [AW-1:0]    readAddr,
    output var  logic [WIDTH-1:0] readData
);
    logic [WIDTH-1:0] store [DEPTH];   // word array

    // write and registered read
    always_ff @(posedge clk_sys) begin
        if (writeEn) begin
            store[writeAddr] <= writeData;
        end
        readData <= store[readAddr];
    end
endmodule
`default_nettype wire

//--- rtl/dmap_port.sv
/*
 * serial bus slave port giving a host access to program RAM, data and
 * coefficient memory, the general control register and channel status.
 * assumes the bus clock is far slower than clk_sys and that the processor
 * pulses busTransferInstruction with its read value on dspReadData.
 */
`timescale 1ns/1ns
`default_nettype none
module dmap_port
    import dmap_pkg::*;
#(
    parameter int PROGRAM_RAM_DEPTH = dmap_pkg::DMAP_PROGRAM_RAM_DEPTH
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // serial bus pins
    input  wire logic        sclPin,
    input  wire logic        sdaIn,
    output var  logic        sdaOut,
    output var  logic        sdaOe,
    input  wire logic        addressSelectPin,
    // processor memory side
    output var  logic [15:0] dspAddr,
    output var  logic        dspDataWrite,
    output var  logic        dspCoefWrite,
    output var  logic [23:0] dspWriteData,
    input  wire logic        busTransferInstruction,
    input  wire logic [23:0] dspReadData,
    // channel status capture
    input  wire logic        statusLoad,
    input  wire logic [19:0] rightStatusLowBits,
    input  wire logic [19:0] rightStatusHighBits,
    // control outputs
    output var  logic [4:0]  synthDivide,
    output var  logic        synthDouble,
    output var  logic        programCounterHold,
    output var  logic [2:0]  clockMultiple,
    output var  logic [1:0]  synthRange,
    output var  logic [1:0]  converterClockSource,
    output var  logic        systemClockPinOff,
    output var  logic        fixedRateClockChoice
);
    import dmap_pkg::*;

    localparam int PAW = $clog2(PROGRAM_RAM_DEPTH);

    // synchronised pins and their last values
    logic [2:0]   pinSync;        // scl, sda, address select after two stages
    logic         sclS;
    logic         sdaS;
    logic         addrSel;
    logic         sclPrev;
    logic         sdaPrev;
    logic         sclRise;
    logic         sclFall;
    logic         startCond;
    logic         stopCond;

    // protocol state
    dmap_state_t  state;
    logic [3:0]   bitCnt;         // 0..7 data bits, 8 is the acknowledge slot
    logic [7:0]   rxByte;         // bits shifted in on rising scl
    logic [7:0]   txShift;        // byte being sent
    logic [31:0]  txWord;         // rest of the word being sent
    logic         masterAck;      // master pulled sda low in its slot
    logic [2:0]   byteIdx;        // byte position within the word
    logic [15:0]  memAddr;        // current memory address
    logic [31:0]  wordBuf;        // assembled write word
    logic         devMatch;       // received byte names this device

    // completed write word
    logic         wordWrite;
    logic [15:0]  wordAddr;
    logic [31:0]  wordData;

    // register contents
    logic [23:0]  processorGeneralControl;
    logic [19:0]  rightChannelStatusLow;
    logic [19:0]  rightChannelStatusHigh;
    logic [23:0]  readHolding;    // processor value latched for the bus

    // decode and read mux
    dmap_target_t target;         // target of memAddr
    dmap_target_t wTarget;        // target of the completed write
    logic [2:0]   wordLen;
    logic         lastByte;
    logic [31:0]  readWord;       // word aligned MSB first
    logic [7:0]   loadByte;       // next byte to send
    logic [31:0]  pramRdata;
    logic [PAW-1:0] pramRaddr;
    logic [PAW-1:0] pramWaddr;
    logic         ackByte;        // the byte in flight gets acknowledged
    logic         rxState;

    // pin synchroniser
    dmap_sync #(
        .WIDTH (3)
    ) uSync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .asyncIn ({sclPin, sdaIn, addressSelectPin}),
        .syncOut (pinSync)
    );

    assign sclS    = pinSync[2];
    assign sdaS    = pinSync[1];
    assign addrSel = pinSync[0];

    // previous pin levels for edge and condition detection
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    assign sclRise   = sclS & ~sclPrev;
    assign sclFall   = ~sclS & sclPrev;
    assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopCond  = sclS & sclPrev & ~sdaPrev & sdaS;

    // open drain: the pin is only ever pulled low
    assign sdaOut = 1'b0;

    // word length follows the address held
    assign target   = dmap_decode(memAddr);
    assign wTarget  = dmap_decode(wordAddr);
    assign wordLen  = dmap_word_len(target);
    assign lastByte = (byteIdx == wordLen - 3'h1);
    assign devMatch = (rxByte[7:1] == {DMAP_DEV_ADDR_HI, addrSel});
    assign rxState  = (state == ST_ADRH) || (state == ST_ADRL) || (state == ST_WR);
    // every memory address is acknowledged, reserved ones too
    assign ackByte  = rxState || ((state == ST_DEV) && devMatch);

    // program RAM index, both ports
    assign pramRaddr = PAW'(memAddr - DMAP_PROGRAM_RAM_BASE);
    assign pramWaddr = PAW'(wordAddr - DMAP_PROGRAM_RAM_BASE);

    // read word, aligned so that the first byte sits on top
    always_comb begin
        case (target)
            TGT_PROGRAM_RAM: readWord = pramRdata;
            TGT_CTRL: readWord = {processorGeneralControl, 8'h00};
            TGT_STLO: readWord = {4'h0, rightChannelStatusLow, 8'h00};
            TGT_STHI: readWord = {4'h0, rightChannelStatusHigh, 8'h00};
            TGT_DATA: readWord = {readHolding, 8'h00};
            TGT_COEF: readWord = {4'h0, readHolding[11:0], 16'h0000};
            default:  readWord = 32'h00000000;
        endcase
    end

    // first byte of a word from the mux, later ones from the word shifter
    assign loadByte = (byteIdx == 3'h0) ? readWord[31:24] : txWord[31:24];

    // program RAM
    dmap_mem #(
        .WIDTH (32),
        .DEPTH (PROGRAM_RAM_DEPTH),
        .AW    (PAW)
    ) uPram (
        .clk_sys   (clk_sys),
        .writeEn   (wordWrite && (wTarget == TGT_PROGRAM_RAM)),
        .writeAddr (pramWaddr),
        .writeData (wordData),
        .readAddr  (pramRaddr),
        .readData  (pramRdata)
    );

    // serial protocol engine; reset aborts any transfer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state     <= ST_IDLE;
            bitCnt    <= 4'h0;
            rxByte    <= 8'h00;
            txShift   <= 8'h00;
            txWord    <= 32'h00000000;
            masterAck <= 1'b0;
            byteIdx   <= 3'h0;
            memAddr   <= 16'h0000;
            wordBuf   <= 32'h00000000;
            sdaOe     <= 1'b0;
            wordWrite <= 1'b0;
            wordAddr  <= 16'h0000;
            wordData  <= 32'h00000000;
        end else begin
            wordWrite <= 1'b0;
            if (startCond) begin
                // start or repeated start: address byte follows, address kept
                state   <= ST_DEV;
                bitCnt  <= 4'hf;                                    // start's own scl fall wraps to 0
                byteIdx <= 3'h0;
                sdaOe   <= 1'b0;
            end else if (stopCond) begin
                // stop: release and wait, a partial word is dropped
                state <= ST_IDLE;
                sdaOe <= 1'b0;
            end else if (sclRise && state != ST_IDLE && state != ST_SKIP) begin
                if (bitCnt != 4'h8) begin
                    rxByte <= {rxByte[6:0], sdaS};
                end else if (state == ST_RD) begin
                    masterAck <= ~sdaS;
                end
            end else if (sclFall && state != ST_IDLE && state != ST_SKIP) begin
                if (bitCnt == 4'h8) begin
                    // acknowledge slot over: act on the byte
                    bitCnt <= 4'h0;
                    sdaOe  <= 1'b0;
                    case (state)
                        ST_DEV: begin
                            if (!devMatch) begin
                                state <= ST_SKIP;
                            end else if (rxByte[0]) begin
                                // read follows earlier address write
                                state   <= ST_RD;
                                txShift <= loadByte;
                                sdaOe   <= ~loadByte[7];
                                txWord  <= (byteIdx == 3'h0) ? {readWord[23:0], 8'h00}
                                                             : {txWord[23:0], 8'h00};
                                if (lastByte) begin
                                    memAddr <= memAddr + 16'h0001;
                                    byteIdx <= 3'h0;
                                end else begin
                                    byteIdx <= byteIdx + 3'h1;
                                end
                            end else begin
                                state <= ST_ADRH;
                            end
                        end
                        ST_ADRH: begin
                            memAddr[15:8] <= rxByte;
                            state         <= ST_ADRL;
                        end
                        ST_ADRL: begin
                            memAddr[7:0] <= rxByte;
                            byteIdx      <= 3'h0;
                            state        <= ST_WR;
                        end
                        ST_WR: begin
                            wordBuf <= {wordBuf[23:0], rxByte};
                            if (lastByte) begin
                                wordWrite <= 1'b1;
                                wordAddr  <= memAddr;
                                wordData  <= {wordBuf[23:0], rxByte};
                                memAddr   <= memAddr + 16'h0001;
                                byteIdx   <= 3'h0;
                            end else begin
                                byteIdx <= byteIdx + 3'h1;
                            end
                        end
                        ST_RD: begin
                            if (masterAck) begin
                                txShift <= loadByte;
                                sdaOe   <= ~loadByte[7];
                                txWord  <= (byteIdx == 3'h0) ? {readWord[23:0], 8'h00}
                                                             : {txWord[23:0], 8'h00};
                                if (lastByte) begin
                                    // advance as the word's last byte is loaded
                                    memAddr <= memAddr + 16'h0001;
                                    byteIdx <= 3'h0;
                                end else begin
                                    byteIdx <= byteIdx + 3'h1;
                                end
                            end else begin
                                // no acknowledge: stay off the bus until stop or start
                                state <= ST_SKIP;
                            end
                        end
                        default: state <= ST_IDLE;
                    endcase
                end else begin
                    bitCnt <= bitCnt + 4'h1;
                    if (bitCnt == 4'h7) begin
                        // acknowledge slot: pull low, or free for the master
                        sdaOe <= (state == ST_RD) ? 1'b0 : ackByte;
                    end else if (state == ST_RD) begin
                        // next data bit, most significant first
                        sdaOe   <= ~txShift[6];
                        txShift <= {txShift[6:0], 1'b0};
                    end
                end
            end
        end
    end

    // control register; reserved bits keep their default
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            processorGeneralControl <= DMAP_CTRL_RESET;
        end else if (wordWrite && wTarget == TGT_CTRL) begin
            processorGeneralControl <= (wordData[23:0] & DMAP_CTRL_WMASK)
                                     | (DMAP_CTRL_RESET & ~DMAP_CTRL_WMASK);
        end
    end

    // control fields out
    assign synthDivide          = processorGeneralControl[DMAP_DIV_LSB +: 5];
    assign synthDouble          = processorGeneralControl[DMAP_DOUBLE_BIT];
    assign programCounterHold   = processorGeneralControl[DMAP_HOLD_BIT];
    assign clockMultiple        = processorGeneralControl[DMAP_MULT_LSB +: 3];
    assign fixedRateClockChoice = processorGeneralControl[DMAP_FIXED_BIT];
    assign synthRange           = processorGeneralControl[DMAP_RANGE_LSB +: 2];
    assign converterClockSource = processorGeneralControl[DMAP_CONV_LSB +: 2];
    assign systemClockPinOff    = processorGeneralControl[DMAP_PINOFF_BIT];

    // channel status capture from the receiver
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rightChannelStatusLow  <= DMAP_STAT_RESET;
            rightChannelStatusHigh <= DMAP_STAT_RESET;
        end else if (statusLoad) begin
            rightChannelStatusLow  <= rightStatusLowBits;
            rightChannelStatusHigh <= rightStatusHighBits;
        end
    end

    // processor value latched only on its transfer instruction
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            readHolding <= 24'h000000;
        end else if (busTransferInstruction) begin
            readHolding <= dspReadData;
        end
    end

    // data and coefficient writes go out to the processor side
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            dspAddr      <= 16'h0000;
            dspDataWrite <= 1'b0;
            dspCoefWrite <= 1'b0;
            dspWriteData <= 24'h000000;
        end else begin
            dspDataWrite <= wordWrite && (wTarget == TGT_DATA);
            dspCoefWrite <= wordWrite && (wTarget == TGT_COEF);
            if (wordWrite) begin
                dspAddr      <= wordAddr;
                dspWriteData <= (wTarget == TGT_COEF) ? {12'h000, wordData[11:0]}
                                                      : wordData[23:0];
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/dmap_port_props.sv
/* assertions on the ports of dmap_port; bound to every instance below */
`timescale 1ns/1ns
`default_nettype none
module dmap_port_props
    import dmap_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        sclPin,
    input wire logic        sdaOut,
    input wire logic        sdaOe,
    // processor side
    input wire logic [15:0] dspAddr,
    input wire logic        dspDataWrite,
    input wire logic        dspCoefWrite,
    input wire logic [23:0] dspWriteData,
    // control fields
    input wire logic [4:0]  synthDivide,
    input wire logic        synthDouble,
    input wire logic        programCounterHold,
    input wire logic [2:0]  clockMultiple,
    input wire logic [1:0]  synthRange,
    input wire logic [1:0]  converterClockSource,
    input wire logic        systemClockPinOff,
    input wire logic        fixedRateClockChoice
);
    wire logic [15:0] ctl = {fixedRateClockChoice, systemClockPinOff, converterClockSource,
        synthRange, clockMultiple, programCounterHold, synthDouble, synthDivide};
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_sda_low: assert property (sdaOut == 1'b0) else $error("sda value high");
    a_oe_scl: assert property ($changed(sdaOe) |-> !sclPin) else $error("sda moved");
    a_data_pulse: assert property (dspDataWrite |=> !dspDataWrite) else $error("long");
    a_coef_pulse: assert property (dspCoefWrite |=> !dspCoefWrite) else $error("long");
    a_one_target: assert property (!(dspDataWrite && dspCoefWrite)) else $error("both");
    a_data_range: assert property (dspDataWrite |-> dspAddr <= DMAP_DATA_LAST)
        else $error("data address");
    a_coef_word: assert property (dspCoefWrite |-> dspAddr >= DMAP_COEF_BASE
        && dspAddr <= DMAP_COEF_LAST && dspWriteData[23:12] == 12'h000) else $error("coef");
    a_ctl_reset: assert property ($rose(arst_n) |-> ctl == 16'h0523) else $error("dflt");
    a_ctl_scl: assert property ($changed(ctl) |-> !sclPin) else $error("ctl moved");
    c_data: cover property (dspDataWrite);
    c_coef: cover property (dspCoefWrite);
    c_ack: cover property ($rose(sdaOe));
endmodule
bind dmap_port dmap_port_props u_props (.*);
`default_nettype wire

//--- bench/dmap_master.sv
/* serial bus master; sda is a pulled-up wire, low when either party pulls */
`timescale 1ns/1ns
`default_nettype none
module dmap_master (
    // clock and bus
    input  wire logic clk_sys,
    input  wire logic sdaOe,
    output var  logic sclPin,
    output var  logic sdaIn
);
    logic sdaM = 1'b1;             // own pull, high when released
    initial sclPin = 1'b1;         // clock stands high between frames
    assign sdaIn = sdaM & ~sdaOe;  // wired and with pull-up
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // start or repeated start, clock left low
    task automatic start();
        w(1); sdaM <= 1'b1; w(3); sclPin <= 1'b1; w(3); sdaM <= 1'b0; w(3); sclPin <= 1'b0;
    endtask
    task automatic stop();
        w(1); sdaM <= 1'b0; w(4); sclPin <= 1'b1; w(3); sdaM <= 1'b1; w(3);
    endtask
    // one bit, 500 ns low then 300 ns high
    task automatic bitx(input logic b, output logic r);
        w(1); sdaM <= b; w(4); sclPin <= 1'b1; w(3); r = sdaIn; sclPin <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
        ack = ~r;
    endtask
    // last set leaves the slot high to end a read
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule
`default_nettype wire

//--- bench/i2c_dsp_memory_access_port_tb.sv
/* bench for dmap_port driven by the master model */
`timescale 1ns/1ns
`default_nettype none
module i2c_dsp_memory_access_port_tb;
    import dmap_pkg::*;
    logic clk_sys = 1'b0, arst_n = 1'b0, addressSelectPin = 1'b0;
    logic busTransferInstruction = 1'b0, statusLoad = 1'b0, k;
    logic [23:0] dspReadData = 24'h000000, lastD;
    logic [19:0] rightStatusLowBits = 20'h00000, rightStatusHighBits = 20'h00000;
    wire logic sclPin, sdaIn, sdaOut, sdaOe, dspDataWrite, dspCoefWrite;
    wire logic [15:0] dspAddr, ctl;
    wire logic [23:0] dspWriteData;
    logic [15:0] lastA;
    logic [31:0] v;
    int fails = 0, checks_done = 0, nWr = 0;
    // rows: written value, control fields, value read back
    logic [63:0] rows [3] = '{{24'h0050c6, 16'h0523, 24'h0050c6},
        {24'h000000, 16'h0000, 24'h000080}, {24'hffffff, 16'hffff, 24'h3cf9fe}};
    initial forever #50 clk_sys = ~clk_sys;
    dmap_port uut (.*, .synthDivide(ctl[4:0]), .synthDouble(ctl[5]),
        .programCounterHold(ctl[6]), .clockMultiple(ctl[9:7]), .synthRange(ctl[11:10]),
        .converterClockSource(ctl[13:12]), .systemClockPinOff(ctl[14]),
        .fixedRateClockChoice(ctl[15]));
    dmap_master m (.*);
    // records each memory word handed to the processor
    always @(posedge clk_sys) if (dspDataWrite === 1'b1 || dspCoefWrite === 1'b1) begin
        nWr <= nWr + 1; lastA <= dspAddr; lastD <= dspWriteData; end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin fails++; $display("[ERR] %s exp %h seen %h", nm, exp, seen); end
    endtask
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic adr(input logic [15:0] a);
        m.start(); m.wr(8'h3c, k); chk("ackdev", k, 1); m.wr(a[15:8], k); chk("ackh", k, 1);
        m.wr(a[7:0], k); chk("ackl", k, 1);
    endtask
    task automatic put(input logic [31:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin m.wr(d[8*i+:8], k); chk("ackd", k, 1); end
    endtask
    task automatic get(input int n, input logic last, output logic [31:0] d);
        d = 0; for (int i = n - 1; i >= 0; i--) m.rd(last && i == 0, d[8*i+:8]);
    endtask
    task automatic rdh(input logic [15:0] a);
        adr(a); m.start(); m.wr(8'h3d, k); chk("ackrd", k, 1);
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        results();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        chk("rstctl", ctl, 16'h0523);
        repeat (3) @(posedge clk_sys);
        foreach (rows[i]) begin
            adr(DMAP_CTRL); put(rows[i][63:40], 3); m.stop();
            chk("ctl", ctl, rows[i][39:24]);
            rdh(DMAP_CTRL); get(3, 1, v); m.stop(); chk("ctlrd", v, rows[i][23:0]);
        end
        adr(DMAP_CTRL); m.wr(8'h00, k); arst_n <= 1'b0; @(posedge clk_sys); arst_n <= 1'b1;
        chk("abort", ctl, 16'h0523); chk("abortoe", sdaOe, 0); m.stop();
        addressSelectPin <= 1'b1; m.start(); m.wr(8'h3c, k); chk("pin0", k, 0); m.stop();
        m.start(); m.wr(8'h3e, k); chk("pin1", k, 1); m.stop(); addressSelectPin <= 1'b0;
        adr(16'h0100); put(32'h123456, 3); put(32'habcdef, 3); m.stop();
        chk("nwr", nWr, 2); chk("inc", lastA, 16'h0101); chk("wd", lastD, 24'habcdef);
        adr(16'h0ff4); put(32'h777777, 3); m.stop(); chk("rsvd", nWr, 2);
        adr(16'h1000); put(32'hf123, 2); m.stop();
        chk("cf", nWr, 3); chk("ca", lastA, 16'h1000); chk("cd", lastD, 24'h000123);
        adr(16'h25fe); put(32'hdeadbeef, 4); put(32'h01234567, 4); m.stop();
        rdh(16'h25fe); get(4, 0, v); chk("p0", v, 32'hdeadbeef);
        get(4, 1, v); m.stop(); chk("p1", v, 32'h01234567);
        rdh(DMAP_PROGRAM_ROM_BASE); get(4, 1, v); m.stop(); chk("rom", v, 0);
        rightStatusLowBits <= 20'habcde; rightStatusHighBits <= 20'h13579; statusLoad <= 1'b1;
        @(posedge clk_sys); statusLoad <= 1'b0;
        rdh(DMAP_STAT_LO); get(3, 0, v); chk("stlo", v, 24'h0abcde);
        get(3, 1, v); chk("sthi", v, 24'h013579); chk("rel", sdaOe, 0); m.stop();
        dspReadData <= 24'h5a5a5a; busTransferInstruction <= 1'b1; @(posedge clk_sys);
        busTransferInstruction <= 1'b0; dspReadData <= 24'h111111;
        rdh(16'h0010); get(3, 1, v); m.stop(); chk("hold", v, 24'h5a5a5a);
        results();
    end
endmodule
`default_nettype wire
